// >>> design/rmc_regs.svh
// Overview of operation
// - Host configures module with ASCII command strings.
// - Only exact case-sensitive, space-free commands match.
// - Acknowledge is A then C then K.
// - Baud commands one to five select rates.
// - Channel zero European, channel one US.
// - Handshake commands switch flow control on/off.
// - Restore command returns factory default settings.
// - Test commands zero to five select modes.
// - Busy held high during power-up calibration.
// - After calibration, enter receive state by default.
// - Standard rates to 38.4k; 76.8k optional.
`ifndef RMC_REGS_SVH
`define RMC_REGS_SVH

`define RMC_CTRL_OFF 12'h000
`define RMC_STATUS_OFF 12'h004
`define RMC_COUNT_OFF 12'h008
`define RMC_CTRL_RESET 32'h0000_0000
`define RMC_CTRL_FAST_BIT 0

`define RMC_ST_BUSY_BIT 0
`define RMC_ST_RX_BIT 1
`define RMC_ST_BAUD_LSB 4
`define RMC_ST_BAUD_MSB 6
`define RMC_ST_CHAN_BIT 8
`define RMC_ST_FLOW_BIT 9
`define RMC_ST_TEST_LSB 12
`define RMC_ST_TEST_MSB 14
`define RMC_ST_STATE_LSB 16
`define RMC_ST_STATE_MSB 18

`define RMC_CLK_HZ 40000000
`define RMC_CLK_PERIOD_NS 25
`define RMC_CAL_TIME_US 7500
`define RMC_CAL_CYCLES ((`RMC_CAL_TIME_US * 1000) / `RMC_CLK_PERIOD_NS)

`define RMC_BAUD_2400 3'h1
`define RMC_BAUD_4800 3'h2
`define RMC_BAUD_9600 3'h3
`define RMC_BAUD_19200 3'h4
`define RMC_BAUD_38400 3'h5
`define RMC_BAUD_DEFAULT `RMC_BAUD_19200
`define RMC_CHAN_DEFAULT 1'b1
`define RMC_FLOW_DEFAULT 1'b0

`define RMC_DIV_2400 16'(`RMC_CLK_HZ / 2400)
`define RMC_DIV_4800 16'(`RMC_CLK_HZ / 4800)
`define RMC_DIV_9600 16'(`RMC_CLK_HZ / 9600)
`define RMC_DIV_19200 16'(`RMC_CLK_HZ / 19200)
`define RMC_DIV_38400 16'(`RMC_CLK_HZ / 38400)
`define RMC_DIV_76800 16'(`RMC_CLK_HZ / 76800)

`define RMC_PREFIX 56'h45525f434d4423
`define RMC_PREFIX_LEN 3'h7
`define RMC_CH_A 8'h41
`define RMC_CH_C 8'h43
`define RMC_CH_K 8'h4b
`define RMC_CH_U 8'h55
`define RMC_CH_H 8'h48
`define RMC_CH_R 8'h52
`define RMC_CH_T 8'h54
`define RMC_CH_E 8'h45
`define RMC_CH_0 8'h30
`define RMC_VERSION_LEN 3'h4

`endif

// >>> design/rmc_pkg.sv
package rmc_pkg;

    typedef enum logic [2:0] {
        st_cal = 3'b000,
        st_prefix = 3'b001,
        st_letter = 3'b010,
        st_digit = 3'b011,
        st_ack = 3'b100,
        st_apply = 3'b101,
        st_version = 3'b110
    } rmc_state_t;

    typedef enum logic [1:0] {
        rf_receive = 2'b00,
        rf_preamble = 2'b01,
        rf_carrier = 2'b10,
        rf_sensitivity = 2'b11
    } rmc_rf_t;

    typedef struct packed {
        logic [2:0] baud;
        logic channel_us;
        logic flow_on;
    } rmc_cfg_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rmc_byte_t;

endpackage

// >>> design/rmc_baud_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmc_regs.svh"

module rmc_baud_gen (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] baud,
    input wire logic fast_en,
    output logic tick
);

    logic [15:0] div;
    logic [15:0] cnt_r;

    always_comb begin
        case (baud)
            `RMC_BAUD_2400: div = `RMC_DIV_2400;
            `RMC_BAUD_4800: div = `RMC_DIV_4800;
            `RMC_BAUD_9600: div = `RMC_DIV_9600;
            `RMC_BAUD_38400: div = `RMC_DIV_38400;
            default: div = `RMC_DIV_19200;
        endcase
        if (fast_en) begin
            div = `RMC_DIV_76800;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
            tick <= 1'b0;
        end else if (cnt_r >= div - 16'h0001) begin
            cnt_r <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// >>> design/rmc_cmd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmc_regs.svh"

module rmc_cmd_top #(
    parameter int unsigned CAL_CYCLES = `RMC_CAL_CYCLES,
    // Version string reported by the version test; the value is arbitrary.
    parameter logic [31:0] VERSION_STR = 32'h302e3030
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rmc_pkg::rmc_byte_t rx_byte,
    output rmc_pkg::rmc_byte_t tx_byte,
    input wire logic tx_ready,
    output logic baud_tick,
    output logic busy,
    output rmc_pkg::rmc_rf_t rf_mode,
    output logic channel_us,
    output logic flow_ctrl_en,
    output logic host_cts,
    output logic [2:0] test_mode
);

    rmc_pkg::rmc_state_t state_r;
    rmc_pkg::rmc_cfg_t cfg_r;
    rmc_pkg::rmc_cfg_t cfg_default;
    logic [31:0] ctrl_r;
    logic [31:0] cal_cnt_r;
    logic [2:0] idx_r;
    logic [7:0] letter_r;
    logic [7:0] digit_r;
    logic [2:0] test_r;
    logic [15:0] accepted_r;
    logic [15:0] rejected_r;
    logic [7:0] ch;
    logic [7:0] prefix_ch;
    logic [7:0] ack_ch;
    logic [7:0] ver_ch;
    logic cmd_legal;
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;
    logic rx_take;
    logic resync;
    localparam logic [55:0] PREFIX_STR = `RMC_PREFIX;

    assign ch = rx_byte.data;
    assign rx_take = rx_byte.valid && (state_r != rmc_pkg::st_cal)
        && (state_r != rmc_pkg::st_apply) && (state_r != rmc_pkg::st_version);
    assign resync = (ch == `RMC_CH_E);

    assign cfg_default.baud = `RMC_BAUD_DEFAULT;
    assign cfg_default.channel_us = `RMC_CHAN_DEFAULT;
    assign cfg_default.flow_on = `RMC_FLOW_DEFAULT;

    // Selects the expected prefix character for the current position.
    always_comb begin
        prefix_ch = 8'h00;
        for (int i = 0; i < 7; i++) begin
            if (idx_r == 3'(i)) begin
                prefix_ch = PREFIX_STR[55 - 8 * i -: 8];
            end
        end
    end

    always_comb begin
        case (idx_r)
            3'h0: ack_ch = `RMC_CH_A;
            3'h1: ack_ch = `RMC_CH_C;
            default: ack_ch = `RMC_CH_K;
        endcase
    end

    always_comb begin
        case (idx_r)
            3'h0: ver_ch = VERSION_STR[31:24];
            3'h1: ver_ch = VERSION_STR[23:16];
            3'h2: ver_ch = VERSION_STR[15:8];
            default: ver_ch = VERSION_STR[7:0];
        endcase
    end

    // Only the documented letter and digit pairs form a command.
    always_comb begin
        case (letter_r)
            `RMC_CH_U: cmd_legal = (digit_r >= 8'h31) && (digit_r <= 8'h35);
            `RMC_CH_C: cmd_legal = (digit_r == 8'h30) || (digit_r == 8'h31);
            `RMC_CH_H: cmd_legal = (digit_r == 8'h31) || (digit_r == 8'h32);
            `RMC_CH_R: cmd_legal = (digit_r == 8'h31);
            `RMC_CH_T: cmd_legal = (digit_r >= 8'h30) && (digit_r <= 8'h35);
            default: cmd_legal = 1'b0;
        endcase
    end

    // Power-up calibration timer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_cnt_r <= 32'h0000_0000;
            busy <= 1'b1;
        end else if (state_r == rmc_pkg::st_cal) begin
            if (cal_cnt_r >= CAL_CYCLES - 1) begin
                busy <= 1'b0;
            end else begin
                cal_cnt_r <= cal_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Command parser and acknowledge matcher.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= rmc_pkg::st_cal;
            idx_r <= 3'h0;
            letter_r <= 8'h00;
            digit_r <= 8'h00;
        end else begin
            case (state_r)
                rmc_pkg::st_cal: begin
                    if (cal_cnt_r >= CAL_CYCLES - 1) begin
                        state_r <= rmc_pkg::st_prefix;
                        idx_r <= 3'h0;
                    end
                end
                rmc_pkg::st_prefix: begin
                    if (rx_take) begin
                        if (ch == prefix_ch) begin
                            if (idx_r == `RMC_PREFIX_LEN - 3'h1) begin
                                state_r <= rmc_pkg::st_letter;
                                idx_r <= 3'h0;
                            end else begin
                                idx_r <= idx_r + 3'h1;
                            end
                        end else begin
                            idx_r <= resync ? 3'h1 : 3'h0;
                        end
                    end
                end
                rmc_pkg::st_letter: begin
                    if (rx_take) begin
                        letter_r <= ch;
                        state_r <= rmc_pkg::st_digit;
                    end
                end
                rmc_pkg::st_digit: begin
                    if (rx_take) begin
                        digit_r <= ch;
                        state_r <= rmc_pkg::st_ack;
                        idx_r <= 3'h0;
                    end
                end
                rmc_pkg::st_ack: begin
                    if (!cmd_legal) begin
                        state_r <= rmc_pkg::st_prefix;
                        idx_r <= 3'h0;
                    end else if (rx_take) begin
                        if (ch == ack_ch) begin
                            if (idx_r == 3'h2) begin
                                state_r <= rmc_pkg::st_apply;
                            end
                            idx_r <= idx_r + 3'h1;
                        end else begin
                            state_r <= rmc_pkg::st_prefix;
                            idx_r <= resync ? 3'h1 : 3'h0;
                        end
                    end
                end
                rmc_pkg::st_apply: begin
                    idx_r <= 3'h0;
                    if (letter_r == `RMC_CH_T && digit_r == 8'h33) begin
                        state_r <= rmc_pkg::st_version;
                    end else begin
                        state_r <= rmc_pkg::st_prefix;
                    end
                end
                rmc_pkg::st_version: begin
                    if (tx_byte.valid && tx_ready) begin
                        if (idx_r == `RMC_VERSION_LEN - 3'h1) begin
                            state_r <= rmc_pkg::st_prefix;
                            idx_r <= 3'h0;
                        end else begin
                            idx_r <= idx_r + 3'h1;
                        end
                    end
                end
                default: begin
                    state_r <= rmc_pkg::st_prefix;
                    idx_r <= 3'h0;
                end
            endcase
        end
    end

    // Configuration applied once a command is acknowledged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_r.baud <= `RMC_BAUD_DEFAULT;
            cfg_r.channel_us <= `RMC_CHAN_DEFAULT;
            cfg_r.flow_on <= `RMC_FLOW_DEFAULT;
            test_r <= 3'h0;
        end else if (state_r == rmc_pkg::st_apply) begin
            case (letter_r)
                `RMC_CH_U: cfg_r.baud <= digit_r[2:0];
                `RMC_CH_C: cfg_r.channel_us <= digit_r[0];
                `RMC_CH_H: cfg_r.flow_on <= (digit_r == 8'h31);
                `RMC_CH_R: begin
                    cfg_r <= cfg_default;
                    test_r <= 3'h0;
                end
                `RMC_CH_T: test_r <= digit_r[2:0];
                default: test_r <= test_r;
            endcase
        end
    end

    // Command statistics for software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accepted_r <= 16'h0000;
            rejected_r <= 16'h0000;
        end else if (state_r == rmc_pkg::st_apply) begin
            accepted_r <= accepted_r + 16'h0001;
        end else if (state_r == rmc_pkg::st_ack && !cmd_legal) begin
            rejected_r <= rejected_r + 16'h0001;
        end
    end

    // Version bytes handed to the serial transmitter.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_byte <= '0;
        end else if (state_r == rmc_pkg::st_version) begin
            tx_byte.valid <= !(tx_byte.valid && tx_ready
                && idx_r == `RMC_VERSION_LEN - 3'h1);
            tx_byte.data <= (tx_byte.valid && tx_ready) ? VERSION_STR[23:16] : ver_ch;
            if (tx_byte.valid && tx_ready) begin
                case (idx_r)
                    3'h0: tx_byte.data <= VERSION_STR[23:16];
                    3'h1: tx_byte.data <= VERSION_STR[15:8];
                    default: tx_byte.data <= VERSION_STR[7:0];
                endcase
            end
        end else begin
            tx_byte.valid <= 1'b0;
        end
    end

    // Radio state follows the selected test mode, receive otherwise.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rf_mode <= rmc_pkg::rf_receive;
        end else if (state_r == rmc_pkg::st_cal) begin
            rf_mode <= rmc_pkg::rf_receive;
        end else begin
            case (test_r)
                3'h1: rf_mode <= rmc_pkg::rf_preamble;
                3'h2: rf_mode <= rmc_pkg::rf_carrier;
                3'h4: rf_mode <= rmc_pkg::rf_sensitivity;
                default: rf_mode <= rmc_pkg::rf_receive;
            endcase
        end
    end

    assign channel_us = cfg_r.channel_us;
    assign flow_ctrl_en = cfg_r.flow_on;
    assign test_mode = test_r;
    assign host_cts = !busy && (!cfg_r.flow_on || state_r != rmc_pkg::st_version);

    rmc_baud_gen u_baud (
        .pclk(pclk),
        .presetn(presetn),
        .baud(cfg_r.baud),
        .fast_en(ctrl_r[`RMC_CTRL_FAST_BIT]),
        .tick(baud_tick)
    );

    // APB slave: zero wait states, error on unmapped addresses.
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign addr_ok = (paddr == `RMC_CTRL_OFF) || (paddr == `RMC_STATUS_OFF)
        || (paddr == `RMC_COUNT_OFF);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `RMC_CTRL_RESET;
        end else if (apb_wr && paddr == `RMC_CTRL_OFF) begin
            ctrl_r <= {31'h0000_0000, pwdata[`RMC_CTRL_FAST_BIT]};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (apb_rd) begin
            prdata <= 32'h0000_0000;
            case (paddr)
                `RMC_CTRL_OFF: prdata <= ctrl_r;
                `RMC_STATUS_OFF: begin
                    prdata[`RMC_ST_BUSY_BIT] <= busy;
                    prdata[`RMC_ST_RX_BIT] <= (rf_mode == rmc_pkg::rf_receive);
                    prdata[`RMC_ST_BAUD_MSB:`RMC_ST_BAUD_LSB] <= cfg_r.baud;
                    prdata[`RMC_ST_CHAN_BIT] <= cfg_r.channel_us;
                    prdata[`RMC_ST_FLOW_BIT] <= cfg_r.flow_on;
                    prdata[`RMC_ST_TEST_MSB:`RMC_ST_TEST_LSB] <= test_r;
                    prdata[`RMC_ST_STATE_MSB:`RMC_ST_STATE_LSB] <= state_r;
                end
                `RMC_COUNT_OFF: prdata <= {rejected_r, accepted_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> testbench/rmc_cmd_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
module rmc_cmd_top_chk #(
    parameter int unsigned CAL_CYCLES = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire rmc_pkg::rmc_byte_t rx_byte,
    input wire rmc_pkg::rmc_byte_t tx_byte,
    input wire logic tx_ready,
    input wire logic baud_tick,
    input wire logic busy,
    input wire rmc_pkg::rmc_rf_t rf_mode,
    input wire logic channel_us,
    input wire logic flow_ctrl_en,
    input wire logic host_cts,
    input wire logic [2:0] test_mode
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] cyc_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_r <= 32'h0;
        end else if (cyc_r != 32'hffffffff) begin
            cyc_r <= cyc_r + 32'h1;
        end
    end
    sequence s_cfg_moved;
        $changed(channel_us) || $changed(flow_ctrl_en) || $changed(test_mode);
    endsequence
    sequence s_apply_due;
        $past(rx_byte.valid, 2) || $past(rx_byte.valid, 3);
    endsequence
    a_busy_in_cal: assert property (cyc_r + 1 < CAL_CYCLES |-> busy)
        else $error("busy low during calibration");
    a_busy_done: assert property (cyc_r > CAL_CYCLES + 1 |-> !busy)
        else $error("busy stuck after calibration");
    a_cts_busy: assert property (busy |-> !host_cts)
        else $error("host may send while busy");
    a_rx_in_cal: assert property (busy |-> rf_mode == rmc_pkg::rf_receive)
        else $error("not receiving after power up");
    a_cfg_by_cmd: assert property (s_cfg_moved |-> s_apply_due)
        else $error("setting changed without a command");
    a_tx_hold: assert property (tx_byte.valid && !tx_ready |=> tx_byte.valid && $stable(tx_byte.data))
        else $error("version byte dropped before accept");
    a_test_range: assert property (test_mode <= 3'h5)
        else $error("test mode out of range");
    a_tick_gap: assert property (baud_tick |=> !baud_tick [*8])
        else $error("baud ticks too close");
    a_bus_refuse: assert property (psel && penable && paddr > 12'h008 |-> pslverr && pready)
        else $error("unmapped access not refused");
    a_bus_accept: assert property (psel && penable && paddr <= 12'h008 |-> !pslverr && pready)
        else $error("mapped access refused");
endmodule
bind rmc_cmd_top rmc_cmd_top_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .rx_byte(rx_byte), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .baud_tick(baud_tick), .busy(busy), .rf_mode(rf_mode),
    .channel_us(channel_us), .flow_ctrl_en(flow_ctrl_en), .host_cts(host_cts),
    .test_mode(test_mode));
`default_nettype wire

// >>> testbench/rmc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmc_regs.svh"
module rmc_host_model (
    input wire logic pclk,
    input wire logic slow,
    input wire logic [7:0] ack_gap,
    output rmc_pkg::rmc_byte_t rx_byte,
    output logic tx_ready
);
    logic [1:0] stall_r = 2'h0;
    initial begin
        rx_byte = '{valid: 1'b0, data: 8'h00};
        tx_ready = 1'b0;
    end
    // When slow, only one cycle in four accepts a version byte.
    always @(posedge pclk) begin
        stall_r <= stall_r + 2'h1;
        tx_ready <= !slow || (stall_r == 2'h0);
    end
    // Between characters the line shows the inverse of the last one.
    task automatic put(input logic [7:0] c);
        @(posedge pclk);
        rx_byte <= '{valid: 1'b1, data: c};
        @(posedge pclk);
        rx_byte <= '{valid: 1'b0, data: ~c};
        repeat (3) @(posedge pclk);
    endtask
    task automatic cmd(input logic [7:0] l, input logic [7:0] d, input logic ack,
                       input logic [7:0] flip);
        logic [55:0] p;
        p = `RMC_PREFIX ^ {flip, 48'h0};
        repeat (7) begin
            put(p[55:48]);
            p = p << 8;
        end
        put(l);
        put(d);
        if (ack) begin
            repeat (ack_gap) @(posedge pclk);
            put(`RMC_CH_A);
            put(`RMC_CH_C);
            put(`RMC_CH_K);
        end
    endtask
endmodule
`default_nettype wire

// >>> testbench/radio_module_config_commands_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rmc_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module radio_module_config_commands_tb_top;
    // Version string value is arbitrary.
    localparam logic [31:0] VER = 32'h392e3837;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, tx_ready, baud_tick, busy, channel_us, flow_ctrl_en, host_cts;
    logic slow = 1'b0;
    rmc_pkg::rmc_byte_t rx_byte, tx_byte;
    rmc_pkg::rmc_rf_t rf_mode;
    logic [2:0] test_mode, e_baud = 3'h4, e_tm = 3'h0;
    logic e_ch = 1'b1, e_fl = 1'b0;
    logic [15:0] acc = 16'h0, rej = 16'h0;
    logic [64:0] rd_q[$], ent;
    logic [7:0] tx_q[$], tb_byte;
    int errors = 0, checked = 0, cycles = 0, seed = 11502;
    always #12.5 pclk = ~pclk;
    rmc_cmd_top #(.CAL_CYCLES(16), .VERSION_STR(VER)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_byte(rx_byte), .tx_byte(tx_byte), .tx_ready(tx_ready), .baud_tick(baud_tick),
        .busy(busy), .rf_mode(rf_mode), .channel_us(channel_us),
        .flow_ctrl_en(flow_ctrl_en), .host_cts(host_cts), .test_mode(test_mode));
    rmc_host_model u_host (.pclk(pclk), .slow(slow), .ack_gap(8'h14), .rx_byte(rx_byte),
        .tx_ready(tx_ready));
    task automatic report_and_stop;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
            ent = rd_q.pop_front();
            `CHK("read data", ent[31:0], prdata & ent[63:32])
            `CHK("slave error", ent[64], pslverr)
        end
        if (tx_byte.valid === 1'b1 && tx_ready && tx_q.size() > 0) begin
            tb_byte = tx_q.pop_front();
            `CHK("version byte", tb_byte, tx_byte.data)
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic er);
        rd_q.push_back({er, m, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic status(input logic b);
        logic [31:0] e;
        e = 32'h0;
        e[0] = b;
        e[1] = !(e_tm == 3'h1 || e_tm == 3'h2 || e_tm == 3'h4);
        e[6:4] = e_baud;
        e[8] = e_ch;
        e[9] = e_fl;
        e[14:12] = e_tm;
        rd(`RMC_STATUS_OFF, e, 32'h0000_7373, 1'b0);
    endtask
    task automatic wait_cal;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 100) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic tick_gap(input int e);
        int n;
        n = 0;
        while (baud_tick !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        @(posedge pclk);
        n = 1;
        while (baud_tick !== 1'b1 && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        `CHK("tick period", e, n)
    endtask
    task automatic do_cmd(input logic [7:0] l, input logic [7:0] d);
        int n;
        if (l == `RMC_CH_T && d == 8'h33) begin
            for (int i = 3; i >= 0; i--) tx_q.push_back(VER[8*i +: 8]);
        end
        u_host.cmd(l, d, 1'b1, 8'h0);
        repeat (4) @(posedge pclk);
        acc++;
        case (l)
            `RMC_CH_U: e_baud = d[2:0];
            `RMC_CH_C: e_ch = d[0];
            `RMC_CH_H: e_fl = (d == 8'h31);
            `RMC_CH_T: e_tm = d[2:0];
            default: begin
                e_baud = 3'h4;
                e_ch = 1'b1;
                e_fl = 1'b0;
                e_tm = 3'h0;
            end
        endcase
        status(1'b0);
        n = 0;
        while (tx_q.size() > 0 && n < 400) begin
            @(posedge pclk);
            n++;
        end
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        status(1'b1);
        wait_cal();
        status(1'b0);
        for (int i = 1; i <= 5; i++) do_cmd(`RMC_CH_U, 8'h30 + 8'(i));
        tick_gap(40000000 / 38400);
        apb(1'b1, `RMC_CTRL_OFF, 32'h1);
        rd(`RMC_CTRL_OFF, 32'h1, 32'hffffffff, 1'b0);
        tick_gap(40000000 / 76800);
        apb(1'b1, `RMC_CTRL_OFF, 32'h0);
        for (int i = 1; i >= 0; i--) do_cmd(`RMC_CH_C, 8'h30 + 8'(i));
        for (int i = 2; i >= 1; i--) do_cmd(`RMC_CH_H, 8'h30 + 8'(i));
        slow <= 1'b1;
        for (int i = 0; i <= 5; i++) do_cmd(`RMC_CH_T, 8'h30 + 8'(i));
        do_cmd(`RMC_CH_R, 8'h31);
        u_host.cmd(`RMC_CH_U, 8'h39, 1'b0, 8'h0);
        rej++;
        u_host.cmd(`RMC_CH_U, 8'h31, 1'b1, 8'h20);
        repeat (4) @(posedge pclk);
        status(1'b0);
        rd(`RMC_COUNT_OFF, {rej, acc}, 32'hffffffff, 1'b0);
        apb(1'b1, 12'h010, 32'hffffffff);
        rd(12'h00c, 32'h0, 32'hffffffff, 1'b1);
        for (int k = 0; k < 4; k++) do_cmd(`RMC_CH_U, 8'h31 + 8'($unsigned($random(seed)) % 5));
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        {e_baud, e_ch, e_fl, e_tm} = {3'h4, 1'b1, 1'b0, 3'h0};
        wait_cal();
        status(1'b0);
        repeat (4) @(posedge pclk);
        report_and_stop();
    end
endmodule
`default_nettype wire
